/* rtl/mfm_defs.svh */
// mfm_defs.svh - register map, field positions, reset values and timing for the modem framer
// assumes a 100 MHz system clock and a host on a plain strobe register port
`ifndef MFM_DEFS_SVH
`define MFM_DEFS_SVH
`define MFM_CLK_HZ      100000000
`define MFM_BAUD_LO     1200
`define MFM_BAUD_HI     2400
`define MFM_F_ONE       1200
`define MFM_F_ZERO_LO   1800
`define MFM_F_ZERO_HI   2400
`define MFM_NCO_INC(f, n) ((64'(f) * 64'h100000000) / (64'(n) * 64'(`MFM_BAUD_LO)))
`define MFM_A_MODE      4'h0
`define MFM_A_CTRL      4'h1
`define MFM_A_ADDR      4'h2
`define MFM_A_SYNC      4'h3
`define MFM_A_BSYNC     4'h4
`define MFM_A_TXHEAD    4'h5
`define MFM_A_TXD1      4'h6
`define MFM_A_TXD2      4'h7
`define MFM_A_RXD1      4'h8
`define MFM_A_RXD2      4'h9
`define MFM_A_STAT      4'hA
`define MFM_MODE_DEMOD  2
`define MFM_MODE_MOD    3
`define MFM_MODE_RESET  15
`define MFM_CTL_RATE    1:0
`define MFM_CTL_HEADIRQ 2
`define MFM_CTL_FMT     5:3
`define MFM_CTL_LAST    6
`define MFM_CTL_HANGIE  7
`define MFM_ST_READY    0
`define MFM_ST_SYNC     1
`define MFM_ST_HEADV    2
`define MFM_ST_LAST     3
`define MFM_ST_CRCOK    4
`define MFM_ST_HANG     5
`define MFM_ST_TXREQ    6
`define MFM_ST_HFAIL    7
`define MFM_SYNC_RST    16'hCB23
`define MFM_BSYNC_RST   16'hAAAA
`define MFM_BCAST       8'h40
`define MFM_SHORT_MAX   8'h10
`define MFM_CRC8_POLY   8'h9B
`define MFM_CRC16_POLY  32'h00001021
`define MFM_CRC32_POLY  32'hDB710641
`define MFM_FMT_RAW     3'h0
`define MFM_FMT_HEAD    3'h1
`define MFM_FMT_FEC     3'h3
`define MFM_FMT_SIZED   3'h4
`endif

/* rtl/mfm_modem.sv */
// mfm_modem.sv - msk/ffsk modem and packet framer, register port, tone out, sliced rx in
// assumes rx_sig is the sliced demodulator level from outside the clock domain
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "mfm_defs.svh"
module mfm_modem #(
	parameter int BIT_CYC_LO = `MFM_CLK_HZ / `MFM_BAUD_LO
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        rx_sig,
	output logic             tx_tone,
	output logic             tx_en
);
	localparam int CW = $clog2(BIT_CYC_LO + 1) + 1;
	localparam logic [CW-1:0] BIT_LO = CW'(BIT_CYC_LO - 1);
	localparam logic [CW-1:0] BIT_HI = CW'(BIT_CYC_LO / 2 - 1);
	localparam logic [CW-1:0] T_MIN  = CW'(BIT_CYC_LO / 6);
	localparam logic [CW-1:0] T_SM   = CW'(BIT_CYC_LO * 7 / 24);
	localparam logic [CW-1:0] T_ML   = CW'(BIT_CYC_LO * 5 / 12);
	localparam logic [CW-1:0] T_MAX  = CW'(BIT_CYC_LO * 7 / 12);
	// tone steps scale with the bit period, so cycles per bit hold for any period
	localparam logic [31:0] INC_ONE  = 32'(`MFM_NCO_INC(`MFM_F_ONE, BIT_CYC_LO));
	localparam logic [31:0] INC_Z_LO = 32'(`MFM_NCO_INC(`MFM_F_ZERO_LO, BIT_CYC_LO));
	localparam logic [31:0] INC_Z_HI = 32'(`MFM_NCO_INC(`MFM_F_ZERO_HI, BIT_CYC_LO));

	function automatic logic [3:0] fec_par(input logic [7:0] d);
		fec_par = {d[7]^d[6]^d[5]^d[3]^d[2], d[7]^d[6]^d[4]^d[1]^d[0],
			d[7]^d[5]^d[4]^d[3]^d[1], d[6]^d[5]^d[4]^d[2]^d[0]};
	endfunction

	// single-error correction from the syndrome column
	function automatic logic [7:0] fec_fix(input logic [11:0] c);
		logic [3:0] s;
		logic [7:0] d;
		d = c[11:4];
		s = c[3:0] ^ fec_par(d);
		for (int i = 0; i < 8; i++)
			if (s == fec_par(8'(1 << i)))
				d[i] = ~d[i];
		fec_fix = d;
	endfunction

	function automatic logic [7:0] crc8(input logic [23:0] b);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = (c[7] ^ b[i]) ? ((c << 1) ^ `MFM_CRC8_POLY) : (c << 1);
		crc8 = c;
	endfunction

	function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [15:0] d,
		input logic wide);
		logic fb;
		logic [31:0] r;
		r = c;
		for (int i = 15; i >= 0; i--)
		begin
			fb = d[i] ^ (wide ? r[31] : r[15]);
			r = r << 1;
			if (fb)
				r = r ^ (wide ? `MFM_CRC32_POLY : `MFM_CRC16_POLY);
			if (!wide)
				r[31:16] = 16'h0000;
		end
		crc_upd = r;
	endfunction

	function automatic logic [47:0] head_code(input logic [31:0] b);
		head_code = {b[31:24], fec_par(b[31:24]), b[23:16], fec_par(b[23:16]),
			b[15:8], fec_par(b[15:8]), b[7:0], fec_par(b[7:0])};
	endfunction

	// registers
	logic        demod_en_q, mod_en_q, demod_d1_q, mod_d1_q;
	logic [7:0]  ctrl_q, addr_q, stat_q;
	logic [15:0] sync_q, bsync_q, txhead_q, txd1_q, txd2_q, rxd1_q, rxd2_q, rdata_q;
	mfm_pkg::mfm_rate_t lock_q;
	mfm_pkg::mfm_tx_st_t tx_st_q, tx_ns;
	mfm_pkg::mfm_rx_st_t rx_st_q;

	wire we_mode = wr && addr == `MFM_A_MODE;
	wire cmd_rst = we_mode && wdata[`MFM_MODE_RESET];
	wire rd_stat = rd && addr == `MFM_A_STAT;
	wire [1:0] rate_sel = ctrl_q[`MFM_CTL_RATE];
	wire [2:0] tx_fmt = ctrl_q[`MFM_CTL_FMT];
	wire head_irq = ctrl_q[`MFM_CTL_HEADIRQ];
	wire tx_done;
	wire [7:0] stat_set;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			demod_en_q <= 1'b0;
			mod_en_q   <= 1'b0;
			ctrl_q     <= 8'h00;
			addr_q     <= 8'h00;
			sync_q     <= `MFM_SYNC_RST;
			bsync_q    <= `MFM_BSYNC_RST;
			txhead_q   <= 16'h0000;
			txd1_q     <= 16'h0000;
			txd2_q     <= 16'h0000;
		end
		else
		begin
			if (we_mode)
			begin
				demod_en_q <= wdata[`MFM_MODE_DEMOD];
				mod_en_q   <= wdata[`MFM_MODE_MOD];
			end
			if (wr && addr == `MFM_A_CTRL)
				ctrl_q <= wdata[7:0];
			else if (tx_done)
				ctrl_q[`MFM_CTL_LAST] <= 1'b0;
			if (wr && addr == `MFM_A_ADDR)
				addr_q <= wdata[15:8];
			if (cmd_rst)
				sync_q <= `MFM_SYNC_RST;
			else if (wr && addr == `MFM_A_SYNC)
				sync_q <= wdata;
			if (wr && addr == `MFM_A_BSYNC)
				bsync_q <= wdata;
			if (wr && addr == `MFM_A_TXHEAD)
				txhead_q <= wdata;
			if (wr && addr == `MFM_A_TXD1)
				txd1_q <= wdata;
			if (wr && addr == `MFM_A_TXD2)
				txd2_q <= wdata;
		end
	end

	// read mux, data one cycle after the strobe
	logic [15:0] rmux;
	always_comb
	begin
		unique case (addr)
			`MFM_A_MODE:   rmux = {12'h000, mod_en_q, demod_en_q, 2'b00};
			`MFM_A_CTRL:   rmux = {8'h00, ctrl_q};
			`MFM_A_ADDR:   rmux = {addr_q, 8'h00};
			`MFM_A_SYNC:   rmux = sync_q;
			`MFM_A_BSYNC:  rmux = bsync_q;
			`MFM_A_TXHEAD: rmux = txhead_q;
			`MFM_A_TXD1:   rmux = txd1_q;
			`MFM_A_TXD2:   rmux = txd2_q;
			`MFM_A_RXD1:   rmux = rxd1_q;
			`MFM_A_RXD2:   rmux = rxd2_q;
			`MFM_A_STAT:   rmux = {4'h0, tx_st_q != mfm_pkg::TX_IDLE,
				rx_st_q != mfm_pkg::RX_IDLE, lock_q, stat_q};
			default:       rmux = 16'h0000;
		endcase
	end

	// sticky flags: clear on status read, a coincident set wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_q <= 16'h0000;
			stat_q  <= 8'h00;
		end
		else
		begin
			rdata_q <= rd ? rmux : 16'h0000;
			stat_q  <= (rd_stat ? 8'h00 : stat_q) | stat_set;
		end
	end
	assign rdata = rdata_q;

	// transmit: bit timer, nco and framing shifter
	logic [CW-1:0] tb_q;
	logic [31:0]   phase_q, tx_crc_q;
	logic [47:0]   tx_sh_q, tx_nsh;
	logic [5:0]    tx_n_q, tx_nn;
	logic          tx_sel_q, tx_take;
	wire tx_hi = rate_sel == mfm_pkg::RATE_HI;
	wire tx_bit = tx_sh_q[47];
	wire tx_busy = tx_st_q != mfm_pkg::TX_IDLE;
	wire bit_end = tx_busy && tb_q == '0;
	wire tx_start = mod_en_q && !mod_d1_q && !tx_busy;
	wire tx_sized = tx_fmt >= `MFM_FMT_SIZED;
	wire tx_fec = tx_fmt >= `MFM_FMT_FEC;
	wire tx_wide = txhead_q[7:0] > `MFM_SHORT_MAX;
	wire [15:0] tx_word = tx_sel_q ? txd2_q : txd1_q;
	wire [31:0] tx_crc_n = crc_upd(tx_crc_q, tx_word, tx_wide);
	wire [23:0] tx_hb = {txhead_q[15:8], 5'h00, tx_fmt, txhead_q[7:0]};
	wire [47:0] tx_wsh = tx_fec ? {tx_word[15:8], fec_par(tx_word[15:8]),
		tx_word[7:0], fec_par(tx_word[7:0]), 24'h000000} : {tx_word, 32'h00000000};
	wire [5:0] tx_wn = tx_fec ? 6'd24 : 6'd16;
	assign tx_done = bit_end && tx_n_q == 6'd1 && tx_ns == mfm_pkg::TX_IDLE;

	// what follows when the last bit of a field leaves
	always_comb
	begin
		tx_ns = mfm_pkg::TX_IDLE;
		tx_nsh = tx_wsh;
		tx_nn = tx_wn;
		tx_take = 1'b0;
		unique case (tx_st_q)
			mfm_pkg::TX_IDLE: tx_nn = 6'd0;
			mfm_pkg::TX_BSYNC:
			begin
				tx_ns = mfm_pkg::TX_FSYNC;
				tx_nsh = {sync_q, 32'h00000000};
				tx_nn = 6'd16;
			end
			mfm_pkg::TX_FSYNC:
			begin
				tx_ns = mfm_pkg::TX_HEAD;
				tx_nsh = head_code({tx_hb, crc8(tx_hb)});
				tx_nn = 6'd48;
			end
			mfm_pkg::TX_HEAD:
			begin
				tx_ns = tx_fmt == `MFM_FMT_HEAD ? mfm_pkg::TX_IDLE : mfm_pkg::TX_DATA;
				tx_take = tx_fmt != `MFM_FMT_HEAD;
			end
			mfm_pkg::TX_DATA:
				if (!ctrl_q[`MFM_CTL_LAST])
				begin
					tx_ns = mfm_pkg::TX_DATA;
					tx_take = 1'b1;
				end
				else if (tx_sized)
				begin
					tx_ns = mfm_pkg::TX_CRC;
					tx_nsh = tx_wide ? {tx_crc_q, 16'h0000} : {tx_crc_q[15:0], 32'h00000000};
					tx_nn = tx_wide ? 6'd32 : 6'd16;
				end
				else
				begin
					tx_ns = mfm_pkg::TX_HANG;
					tx_nsh = {~tx_bit, 47'h0};
					tx_nn = 6'd1;
				end
			default: tx_nn = 6'd0;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_st_q  <= mfm_pkg::TX_IDLE;
			tx_sh_q  <= 48'h0;
			tx_n_q   <= 6'd0;
			tb_q     <= '0;
			tx_sel_q <= 1'b0;
			tx_crc_q <= 32'h0;
			mod_d1_q <= 1'b0;
		end
		else
		begin
			mod_d1_q <= mod_en_q;
			if (!mod_en_q)
				tx_st_q <= mfm_pkg::TX_IDLE;
			else if (tx_start)
			begin
				tx_sel_q <= 1'b0;
				tx_crc_q <= 32'h0;
				tb_q     <= tx_hi ? BIT_HI : BIT_LO;
				tx_st_q  <= tx_fmt == `MFM_FMT_RAW ? mfm_pkg::TX_DATA : mfm_pkg::TX_BSYNC;
				tx_sh_q  <= tx_fmt == `MFM_FMT_RAW ? {txd1_q, 32'h0} : {bsync_q, 32'h0};
				tx_n_q   <= 6'd16;
			end
			else if (bit_end)
			begin
				tb_q <= tx_hi ? BIT_HI : BIT_LO;
				if (tx_n_q != 6'd1)
				begin
					tx_sh_q <= tx_sh_q << 1;
					tx_n_q  <= tx_n_q - 6'd1;
				end
				else
				begin
					tx_st_q <= tx_ns;
					tx_sh_q <= tx_nsh;
					tx_n_q  <= tx_nn;
					if (tx_take)
					begin
						tx_crc_q <= tx_crc_n;
						tx_sel_q <= tx_fmt != `MFM_FMT_RAW && !tx_sel_q;
					end
				end
			end
			else if (tx_busy)
				tb_q <= tb_q - CW'(1);
		end
	end

	// phase-continuous tone, one msb per audio cycle
	wire [31:0] nco_inc = tx_bit ? INC_ONE : (tx_hi ? INC_Z_HI : INC_Z_LO);
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			phase_q <= 32'h0;
		else
			phase_q <= tx_busy ? phase_q + nco_inc : 32'h0;
	end
	assign tx_tone = phase_q[31];
	assign tx_en = tx_busy;

	property p_tone;
		@(posedge clk) disable iff (rst)
		tx_busy && tx_bit && !tx_hi |=> $past(phase_q) + INC_ONE == phase_q || !tx_busy;
	endproperty
	a_tone: assert property (p_tone) else $error("one bit not sent at the mark tone");

	property p_msb;
		@(posedge clk) disable iff (rst)
		tx_start && tx_fmt == `MFM_FMT_RAW |=> tx_bit == $past(txd1_q[15]);
	endproperty
	a_msb: assert property (p_msb) else $error("word not sent msb first");

	property p_hang;
		@(posedge clk) disable iff (rst)
		tx_st_q == mfm_pkg::TX_HANG && bit_end && ctrl_q[`MFM_CTL_HANGIE]
			|=> !tx_busy && stat_q[`MFM_ST_HANG];
	endproperty
	a_hang: assert property (p_hang) else $error("hang bit end not flagged");

	// receive: synchroniser, half-period classifier, rate lock
	logic rx_s1_q, rx_s2_q, rx_s3_q;
	logic [CW-1:0] iv_q;
	logic [1:0] rc_q, rc_n, need;
	mfm_pkg::mfm_cls_t prev_q, cls;
	wire edge_s = rx_s2_q ^ rx_s3_q;
	always_comb
	begin
		if (iv_q < T_MIN || iv_q >= T_MAX)
			cls = mfm_pkg::CLS_NONE;
		else if (iv_q < T_SM)
			cls = mfm_pkg::CLS_S;
		else if (iv_q < T_ML)
			cls = mfm_pkg::CLS_M;
		else
			cls = mfm_pkg::CLS_L;
	end
	wire acc = edge_s && demod_en_q && (
		(cls == mfm_pkg::CLS_S && rate_sel != mfm_pkg::RATE_LO && lock_q != mfm_pkg::RATE_LO) ||
		(cls == mfm_pkg::CLS_M && rate_sel != mfm_pkg::RATE_HI && lock_q != mfm_pkg::RATE_HI) ||
		(cls == mfm_pkg::CLS_L && lock_q != mfm_pkg::RATE_AUTO));
	assign rc_n = cls == prev_q ? rc_q + 2'd1 : 2'd1;
	assign need = cls == mfm_pkg::CLS_M ? 2'd3 :
		(cls == mfm_pkg::CLS_L && lock_q == mfm_pkg::RATE_HI) ? 2'd1 : 2'd2;
	wire emit = acc && rc_n == need;
	wire rbit = cls == mfm_pkg::CLS_L;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			{rx_s1_q, rx_s2_q, rx_s3_q} <= 3'b000;
			iv_q   <= '0;
			rc_q   <= 2'd0;
			prev_q <= mfm_pkg::CLS_NONE;
			lock_q <= mfm_pkg::RATE_AUTO;
		end
		else
		begin
			{rx_s1_q, rx_s2_q, rx_s3_q} <= {rx_sig, rx_s1_q, rx_s2_q};
			iv_q <= edge_s ? '0 : (iv_q == T_MAX ? iv_q : iv_q + CW'(1));
			if (edge_s)
			begin
				rc_q   <= (acc && !emit) ? rc_n : 2'd0;
				prev_q <= (acc && !emit) ? cls : mfm_pkg::CLS_NONE;
			end
			if (cmd_rst)
				lock_q <= mfm_pkg::RATE_AUTO;
			else if (acc && lock_q == mfm_pkg::RATE_AUTO)
				lock_q <= cls == mfm_pkg::CLS_S ? mfm_pkg::RATE_HI : mfm_pkg::RATE_LO;
		end
	end

	property p_lock;
		@(posedge clk) disable iff (rst)
		lock_q != mfm_pkg::RATE_AUTO && !cmd_rst |=> lock_q == $past(lock_q);
	endproperty
	a_lock: assert property (p_lock) else $error("rate lock changed without reset");

	property p_fixed;
		@(posedge clk) disable iff (rst)
		rate_sel == mfm_pkg::RATE_LO && lock_q == mfm_pkg::RATE_AUTO |=> lock_q != mfm_pkg::RATE_HI;
	endproperty
	a_fixed: assert property (p_fixed) else $error("locked to a rate not selected");

	// receive framer
	logic [47:0] rx_sh_q;
	logic [5:0]  rx_n_q;
	logic [7:0]  rrem_q;
	logic [31:0] rcrc_q;
	logic        rfec_q, rsized_q, rwide_q;
	wire [47:0] rsh_n = {rx_sh_q[46:0], rbit};
	wire sync_hit = rsh_n[15:0] == sync_q;
	wire [7:0] hb0 = fec_fix(rsh_n[47:36]);
	wire [7:0] hb1 = fec_fix(rsh_n[35:24]);
	wire [7:0] hb2 = fec_fix(rsh_n[23:12]);
	wire [7:0] hb3 = fec_fix(rsh_n[11:0]);
	wire head_ok = crc8({hb0, hb1, hb2}) == hb3;
	wire addr_ok = hb0 == addr_q || hb0 == `MFM_BCAST;
	wire [15:0] rw = rfec_q ? {fec_fix(rsh_n[23:12]), fec_fix(rsh_n[11:0])} : rsh_n[15:0];
	wire [31:0] rcrc_n = crc_upd(rcrc_q, rw, rwide_q);
	wire crc_hit = rwide_q ? rsh_n[31:0] == rcrc_q : rsh_n[15:0] == rcrc_q[15:0];
	wire rlast = rx_n_q == 6'd1 && emit;
	wire in_st_srch = rx_st_q == mfm_pkg::RX_SEARCH && emit;
	wire hd_end = rlast && rx_st_q == mfm_pkg::RX_HEAD;
	wire hd_good = hd_end && head_ok && addr_ok;
	wire wd_end = rlast && rx_st_q == mfm_pkg::RX_DATA;
	wire rx_run = demod_en_q && !cmd_rst;
	wire rx_sz = hb1[2:0] >= `MFM_FMT_SIZED;
	wire hd_crc = rx_sz && hb2 == 8'h00;
	wire wd_crc = rsized_q && rrem_q <= 8'h02;
	assign stat_set = rx_run ? {hd_end && !head_ok, tx_take && bit_end && tx_n_q == 6'd1,
		tx_done && tx_st_q == mfm_pkg::TX_HANG && ctrl_q[`MFM_CTL_HANGIE],
		rlast && rx_st_q == mfm_pkg::RX_CRC && crc_hit, rlast && rx_st_q == mfm_pkg::RX_CRC,
		hd_good, in_st_srch && sync_hit && (!head_irq || tx_fmt == `MFM_FMT_RAW), wd_end} :
		{1'b0, tx_take && bit_end && tx_n_q == 6'd1,
		tx_done && tx_st_q == mfm_pkg::TX_HANG && ctrl_q[`MFM_CTL_HANGIE], 5'h00};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_st_q    <= mfm_pkg::RX_IDLE;
			demod_d1_q <= 1'b0;
			rx_sh_q    <= 48'h0;
			rx_n_q     <= 6'd0;
			{rfec_q, rsized_q, rwide_q} <= 3'b000;
			rrem_q     <= 8'h00;
			rcrc_q     <= 32'h0;
		end
		else
		begin
			demod_d1_q <= demod_en_q;
			if (emit)
				rx_sh_q <= rsh_n;
			if (emit && rx_n_q != 6'd1)
				rx_n_q <= rx_n_q - 6'd1;
			if (!rx_run)
				rx_st_q <= mfm_pkg::RX_IDLE;
			else if (rx_st_q == mfm_pkg::RX_IDLE && !demod_d1_q)
				rx_st_q <= mfm_pkg::RX_SEARCH;
			else if (in_st_srch && sync_hit)
			begin
				rx_st_q  <= tx_fmt == `MFM_FMT_RAW ? mfm_pkg::RX_DATA : mfm_pkg::RX_HEAD;
				rx_n_q   <= tx_fmt == `MFM_FMT_RAW ? 6'd16 : 6'd48;
				{rfec_q, rsized_q} <= 2'b00;
				rcrc_q   <= 32'h0;
			end
			else if (hd_end)
			begin
				if (!hd_good)
					rx_st_q <= head_irq ? mfm_pkg::RX_SEARCH : mfm_pkg::RX_IDLE;
				else if (hb1[2:0] <= `MFM_FMT_HEAD)
					rx_st_q <= mfm_pkg::RX_IDLE;
				else
					rx_st_q <= hd_crc ? mfm_pkg::RX_CRC : mfm_pkg::RX_DATA;
				rfec_q   <= hb1[2:0] >= `MFM_FMT_FEC;
				rsized_q <= rx_sz;
				rwide_q  <= hb2 > `MFM_SHORT_MAX;
				rrem_q   <= hb2;
				rx_n_q   <= hd_crc ? (hb2 > `MFM_SHORT_MAX ? 6'd32 : 6'd16) :
					(hb1[2:0] >= `MFM_FMT_FEC ? 6'd24 : 6'd16);
			end
			else if (wd_end)
			begin
				rcrc_q  <= rcrc_n;
				rrem_q  <= rrem_q - 8'h02;
				rx_st_q <= wd_crc ? mfm_pkg::RX_CRC : mfm_pkg::RX_DATA;
				rx_n_q  <= wd_crc ? (rwide_q ? 6'd32 : 6'd16) : (rfec_q ? 6'd24 : 6'd16);
			end
			else if (rlast && rx_st_q == mfm_pkg::RX_CRC)
				rx_st_q <= mfm_pkg::RX_IDLE;
		end
	end

	// receive words: a good head fills rxd1 and rxd2; after that the newest word goes to rxd1 and the older moves to rxd2 unread or not
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rxd1_q <= 16'h0000;
			rxd2_q <= 16'h0000;
		end
		else if (rx_run && hd_good)
		begin
			rxd1_q <= {hb0, hb1};
			rxd2_q <= {hb2, hb3};
		end
		else if (rx_run && wd_end)
		begin
			rxd1_q <= rw;
			rxd2_q <= rxd1_q;
		end
	end

	property p_word;
		@(posedge clk) disable iff (rst)
		rx_run && wd_end |=> stat_q[`MFM_ST_READY] && rxd1_q == $past(rw);
	endproperty
	a_word: assert property (p_word) else $error("received word not posted");

	property p_stop;
		@(posedge clk) disable iff (rst)
		rx_run && in_st_srch && sync_hit |=> rx_st_q != mfm_pkg::RX_SEARCH;
	endproperty
	a_stop: assert property (p_stop) else $error("search kept running after sync");

	property p_hfail;
		@(posedge clk) disable iff (rst)
		rx_run && hd_end && !head_ok && head_irq |=> rx_st_q == mfm_pkg::RX_SEARCH
			&& stat_q[`MFM_ST_HFAIL];
	endproperty
	a_hfail: assert property (p_hfail) else $error("bad head did not restart search");

	property p_sync_rst;
		@(posedge clk) disable iff (rst)
		cmd_rst |=> sync_q == `MFM_SYNC_RST && rx_st_q == mfm_pkg::RX_IDLE;
	endproperty
	a_sync_rst: assert property (p_sync_rst) else $error("reset command did not restore sync");
endmodule

/* rtl/mfm_pkg.sv */
// mfm_pkg.sv - state and code types of the modem framer
// assumes mfm_defs.svh supplies the numeric constants
package mfm_pkg;
	typedef enum logic [6:0] {TX_IDLE = 7'h01, TX_BSYNC = 7'h02, TX_FSYNC = 7'h04,
		TX_HEAD = 7'h08, TX_DATA = 7'h10, TX_CRC = 7'h20, TX_HANG = 7'h40} mfm_tx_st_t;
	typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_SEARCH = 5'h02, RX_HEAD = 5'h04,
		RX_DATA = 5'h08, RX_CRC = 5'h10} mfm_rx_st_t;
	typedef enum logic [1:0] {CLS_NONE = 2'h0, CLS_S = 2'h1, CLS_M = 2'h2,
		CLS_L = 2'h3} mfm_cls_t;
	typedef enum logic [1:0] {RATE_AUTO = 2'h0, RATE_LO = 2'h1, RATE_HI = 2'h2} mfm_rate_t;
endpackage

/* tb/mfm_far_end.sv */
// mfm_far_end.sv - far-end ffsk sender driving the sliced receive input
// assumes the bench clock and the same bit period parameter as the modem
`timescale 1ns/1ps
module mfm_far_end #(
	parameter int BIT_CYC_LO = 480
) (
	input  wire logic clk,
	output logic      rx_sig
);
	initial rx_sig = 1'b0;

	// one word msb first; each edge closes a half period, line holds between frames
	task automatic send_word(input logic [15:0] w, input logic hi);
		int n;
		int len;
		for (int i = 15; i >= 0; i--)
		begin
			n = hi ? (w[i] ? 1 : 2) : (w[i] ? 2 : 3);
			len = (hi ? BIT_CYC_LO / 2 : BIT_CYC_LO) / n;
			repeat (n)
			begin
				repeat (len) @(posedge clk);
				rx_sig <= ~rx_sig;
			end
		end
	endtask
endmodule

/* tb/tb_top.sv */
// tb_top.sv - register-port bench for the modem framer, tone and receive checks
// assumes mfm_defs.svh indices and a short bit period parameter
`timescale 1ns/1ps
`include "mfm_defs.svh"
module tb_top;
	localparam int BIT = 240;
	logic        clk, rst, wr, rd, rx_sig, tx_tone, tx_en, tone_q, peer_sig, loop;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, v;
	int          err_total, n_checks, togg;

	mfm_modem #(.BIT_CYC_LO(BIT)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .rx_sig(rx_sig), .tx_tone(tx_tone), .tx_en(tx_en));
	mfm_far_end #(.BIT_CYC_LO(BIT)) peer (.clk(clk), .rx_sig(peer_sig));
	// loopback feeds the tone back into the receiver for framed transfers
	assign rx_sig = loop ? tx_tone : peer_sig;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// tone edge counter
	always @(posedge clk)
	begin
		if (tx_tone !== tone_q)
			togg++;
		tone_q <= tx_tone;
	end

	task automatic print_verdict;
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_checks++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
			err_total++;
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rx_send(input logic [15:0] w, input logic hi);
		peer.send_word(w, hi);
		repeat (8) @(posedge clk);
	endtask

	// loopback frame, waiting nb fast-rate bit periods (BIT / 2 each): reset command, program, enable both directions
	task automatic loop_run(input logic [15:0] c, input logic [15:0] h, input int nb);
		wr_reg(`MFM_A_MODE, 16'h8000);
		wr_reg(`MFM_A_TXHEAD, h);
		wr_reg(`MFM_A_CTRL, c);
		loop <= 1'b1;
		wr_reg(`MFM_A_MODE, 16'h000C);
		repeat (nb * BIT / 2 + 16) @(posedge clk);
		rd_reg(`MFM_A_STAT, v);
	endtask

	// fmt0 word with last flag and hang flag enabled; tone edges counted mid-bit
	task automatic tx_run(input logic [1:0] rate, input logic [15:0] w);
		int   b, t0, e, k;
		logic x;
		b = (rate == 2'h2) ? BIT / 2 : BIT;
		wr_reg(`MFM_A_TXD1, w);
		wr_reg(`MFM_A_CTRL, 16'h00C0 | {14'h0, rate});
		wr_reg(`MFM_A_MODE, 16'h0000);
		wr_reg(`MFM_A_MODE, 16'h0008);
		k = 0;
		do
		begin
			@(posedge clk);
			#1 k++;
		end
		while (tx_en !== 1'b1 && k < 4);
		chk({15'h0, tx_en}, 16'h0001, "tx enable");
		for (int i = 16; i >= 0; i--)
		begin
			x = (i > 0) ? w[i - 1] : ~w[0];
			e = (rate == 2'h2) ? (x ? 0 : 1) : (x ? 1 : 2);
			repeat (b / 8) @(posedge clk);
			t0 = togg;
			repeat (b * 3 / 4) @(posedge clk);
			chk(16'(togg - t0), 16'(e), "tone edges in bit");
			repeat (b / 8) @(posedge clk);
		end
		repeat (8) @(posedge clk);
		#1 chk({14'h0, tx_en, tx_tone}, 16'h0000, "tx stop");
		rd_reg(`MFM_A_STAT, v);
		chk(v & 16'h0020, 16'h0020, "hang flag");
	endtask

	initial
	begin
		{rst, wr, rd, tone_q} = 4'h8;
		loop = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		err_total = 0;
		n_checks = 0;
		togg = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd_reg(`MFM_A_SYNC, v);
		chk(v, 16'hCB23, "sync after reset");
		rd_reg(4'hB, v);
		chk(v, 16'h0000, "unmapped read");
		wr_reg(`MFM_A_SYNC, 16'h1234);
		rd_reg(`MFM_A_SYNC, v);
		chk(v, 16'h1234, "sync write");
		wr_reg(`MFM_A_MODE, 16'h8000);
		rd_reg(`MFM_A_SYNC, v);
		chk(v, 16'hCB23, "sync after reset cmd");
		tx_run(2'h1, 16'hB4E1);
		tx_run(2'h2, 16'h4D2B);
		wr_reg(`MFM_A_CTRL, 16'h0000);
		wr_reg(`MFM_A_MODE, 16'h0004);
		rx_send(16'hAAAA, 1'b0);
		rx_send(16'hCB23, 1'b0);
		rx_send(16'h5A3C, 1'b0);
		rd_reg(`MFM_A_STAT, v);
		chk(v & 16'h0303, 16'h0103, "sync, ready, rate");
		rd_reg(`MFM_A_RXD1, v);
		chk(v, 16'h5A3C, "rx word");
		rx_send(16'h1111, 1'b0);
		rx_send(16'h2222, 1'b0);
		rd_reg(`MFM_A_RXD1, v);
		chk(v, 16'h2222, "newest word");
		rd_reg(`MFM_A_RXD2, v);
		chk(v, 16'h1111, "older word");
		rx_send(16'h3333, 1'b1);
		rd_reg(`MFM_A_STAT, v);
		chk(v & 16'h0300, 16'h0100, "rate stays locked");
		wr_reg(`MFM_A_MODE, 16'h0000);
		wr_reg(`MFM_A_MODE, 16'h8000);
		rd_reg(`MFM_A_STAT, v);
		chk(v & 16'h0300, 16'h0000, "lock cleared");
		wr_reg(`MFM_A_CTRL, 16'h0002);
		wr_reg(`MFM_A_MODE, 16'h0004);
		rx_send(16'hAAAA, 1'b0);
		rx_send(16'hCB23, 1'b0);
		rd_reg(`MFM_A_STAT, v);
		chk(v & 16'h0003, 16'h0000, "wrong rate ignored");
		rx_send(16'hAAAA, 1'b1);
		rx_send(16'hCB23, 1'b1);
		rx_send(16'h5A3C, 1'b1);
		rd_reg(`MFM_A_STAT, v);
		chk(v & 16'h0303, 16'h0203, "fixed rate sync");
		rd_reg(`MFM_A_RXD1, v);
		chk(v, 16'h5A3C, "fast rx word");
		wr_reg(`MFM_A_TXD1, 16'h9C71);
		loop_run(16'h00D2, 16'h4005, 113);
		chk(v & 16'h0027, 16'h0027, "head, word and hang flags");
		rd_reg(`MFM_A_RXD1, v);
		chk(v, 16'h9C71, "word after head");
		rd_reg(`MFM_A_RXD2, v);
		chk(v, 16'h4002, "head address and format");
		wr_reg(`MFM_A_ADDR, 16'h1200);
		loop_run(16'h00D6, 16'h1207, 113);
		chk(v & 16'h0006, 16'h0004, "flag after head only");
		rd_reg(`MFM_A_RXD2, v);
		chk(v, 16'h1202, "station address head");
		print_verdict();
	end

	initial
	begin
		repeat (90000) @(posedge clk);
		err_total++;
		print_verdict();
	end
endmodule
